// >>> verilog/cgpf_pkg.sv
// Constants shared by the processor glue and power-fail guard.
// Assumes a 20 MHz reference clock and an 8-bit processor with a 16-bit address bus.
package cgpf_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned OSC_DIV         = 2;          // 20 MHz to 10 MHz oscillator rate.
  localparam int unsigned PFR_ASSERT_NS   = 1000;       // Reset follows interrupt shortly after.
  localparam int unsigned PFR_ASSERT_CYC  =
    (PFR_ASSERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PFR_RELEASE_US  = 10000;      // Timing node charge to half supply.
  localparam int unsigned PFR_RELEASE_CYC =
    (PFR_RELEASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RELAY_HOLD_MS   = 1000;       // Relay supply hold-off.
  localparam int unsigned RELAY_HOLD_CYC  =
    (RELAY_HOLD_MS * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS * 1000;
  localparam int unsigned SCAN_DIGIT_US   = 1000;       // Dwell time of one display digit.
  localparam int unsigned SCAN_DIGIT_CYC  = SCAN_DIGIT_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned CNT_W           = 32;

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W     = 16;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned MEM_HALF_BIT = 15;            // Low half RAM, high half ROM.
  localparam int unsigned IO_GRP_MSB = 7;
  localparam int unsigned IO_GRP_LSB = 4;
  localparam int unsigned IO_IDX_MSB = 3;
  localparam logic [3:0]  IO_ANALYZER = 4'h0;
  localparam logic [3:0]  IO_SOURCE   = 4'h1;
  localparam logic [3:0]  IO_DIGIT    = 4'h2;
  localparam logic [3:0]  IO_ANNUN    = 4'h3;
  localparam logic [3:0]  IO_BUSCTL   = 4'h4;
  localparam logic [3:0]  IO_INTSTAT  = 4'h5;

  // ------------------------------------------------------------------
  // Display
  // ------------------------------------------------------------------
  localparam int unsigned DIGITS  = 16;
  localparam int unsigned ANNUN_W = 8;
  localparam int unsigned SEG_W   = 7;
  localparam int unsigned NIB_W   = 4;
  // Segment patterns for hex digits, bit order g f e d c b a.
  localparam logic [6:0] SEG_LUT [16] = '{
    7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
    7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};

endpackage : cgpf_pkg

// >>> verilog/cgpf_sync.sv
// Three-stage input synchroniser for pins that arrive from outside the clock domain.
// Assumes one clock; the output moves only when the second and third stages agree.
`timescale 1ns/10ps
`default_nettype none
module cgpf_sync #(
  parameter int unsigned W        = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] sync_out
);

  // ------------------------------------------------------------------
  // Stages
  // ------------------------------------------------------------------
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // Each bit is accepted once two settled stages hold the same value.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg   <= RST_VAL;
      s2_reg   <= RST_VAL;
      s3_reg   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          sync_out[i] <= s3_reg[i];
        end
      end
    end
  end

endmodule : cgpf_sync
`default_nettype wire

// >>> verilog/cgpf_glue.sv
// Processor glue: power-fail guard, memory and I/O decode, clocks, interrupts, display.
// Assumes all processor and board pins are asynchronous to ref_clk and are synchronised here.
`timescale 1ns/10ps
`default_nettype none
module cgpf_glue #(
  parameter int unsigned PFR_RELEASE_CYC = cgpf_pkg::PFR_RELEASE_CYC,
  parameter int unsigned RELAY_HOLD_CYC  = cgpf_pkg::RELAY_HOLD_CYC,
  parameter int unsigned SCAN_DIGIT_CYC  = cgpf_pkg::SCAN_DIGIT_CYC,
  parameter int unsigned DIGITS          = cgpf_pkg::DIGITS,
  parameter int unsigned ANNUN_W         = cgpf_pkg::ANNUN_W
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  input  wire logic                         supply_low,
  input  wire logic                         cpu_halt_n,
  input  wire logic                         cpu_mreq_n,
  input  wire logic                         cpu_iorq_n,
  input  wire logic                         cpu_rd_n,
  input  wire logic                         cpu_wr_n,
  input  wire logic [cgpf_pkg::ADDR_W-1:0]  cpu_addr,
  input  wire logic [cgpf_pkg::DATA_W-1:0]  cpu_data,
  input  wire logic                         busctl_int,
  input  wire logic                         key_int,
  output logic                              power_fail_interrupt_n,
  output logic                              cpu_nmi_n,
  output logic                              power_fail_reset_n,
  output logic                              ram_cs_n,
  output logic                              rom_cs_n,
  output logic                              mem_rd_n,
  output logic                              mem_wr_n,
  output logic                              io_rd_n,
  output logic                              io_wr_n,
  output logic                              cpu_clk,
  output logic                              cpu_clk_en,
  output logic                              cpu_int_n,
  output logic [1:0]                        int_status,
  output logic                              int_status_oe,
  output logic                              analyzer_write_enable,
  output logic                              source_write_enable,
  output logic                              instr_buf_oe,
  output logic                              disp_buf_oe,
  output logic                              relay_supply_en,
  output logic [cgpf_pkg::SEG_W-1:0]        seg,
  output logic [DIGITS-1:0]                 cathode_n,
  output logic [ANNUN_W-1:0]                annunciator
);

  // ------------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------------
  if (DIGITS < 2 || DIGITS > 16) begin : g_chk_digits
    $error("DIGITS must lie between 2 and 16.");
  end
  if (ANNUN_W < 1 || ANNUN_W > cgpf_pkg::DATA_W) begin : g_chk_annun
    $error("ANNUN_W must lie between 1 and the data width.");
  end
  if (PFR_RELEASE_CYC < 1 || RELAY_HOLD_CYC < 1 || SCAN_DIGIT_CYC < 1) begin : g_chk_cnt
    $error("Timing counts must be at least one cycle.");
  end

  localparam int unsigned BUS_W = cgpf_pkg::ADDR_W + cgpf_pkg::DATA_W + 4;
  localparam int unsigned DIG_W = $clog2(DIGITS);
  localparam int unsigned CW    = cgpf_pkg::CNT_W;

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  logic [BUS_W-1:0]            bus_s;
  logic [3:0]                  misc_s;
  logic [cgpf_pkg::ADDR_W-1:0] addr_s;
  logic [cgpf_pkg::DATA_W-1:0] data_s;
  logic                        mreq_s_n;
  logic                        iorq_s_n;
  logic                        rd_s_n;
  logic                        wr_s_n;
  logic                        low_s;
  logic                        halt_s_n;
  logic                        bint_s;
  logic                        kint_s;

  // Processor bus pins; strobes reset to their idle high level.
  cgpf_sync #(
    .W       (BUS_W),
    .RST_VAL ({4'hF, {(BUS_W-4){1'b0}}})
  ) u_bus_sync (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .pin_in   ({cpu_mreq_n, cpu_iorq_n, cpu_rd_n, cpu_wr_n, cpu_addr, cpu_data}),
    .sync_out (bus_s)
  );

  // Supply comparator, halt and interrupt request pins.
  cgpf_sync #(
    .W       (4),
    .RST_VAL (4'h4)
  ) u_misc_sync (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .pin_in   ({supply_low, cpu_halt_n, busctl_int, key_int}),
    .sync_out (misc_s)
  );

  // Unpacking of the synchronised groups.
  assign {mreq_s_n, iorq_s_n, rd_s_n, wr_s_n, addr_s, data_s} = bus_s;
  assign {low_s, halt_s_n, bint_s, kint_s} = misc_s;

  // ------------------------------------------------------------------
  // Power-fail guard
  // ------------------------------------------------------------------
  logic          pfi_reg;
  logic          ram_cut_reg;
  logic [CW-1:0] pfr_cnt_reg;

  // Interrupt follows the supply comparator and feeds the processor NMI.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pfi_reg                <= 1'b0;
      power_fail_interrupt_n <= 1'b1;
      cpu_nmi_n              <= 1'b1;
    end else begin
      pfi_reg                <= low_s;
      power_fail_interrupt_n <= !low_s;
      cpu_nmi_n              <= !low_s;
    end
  end

  // Halt while the interrupt stands cuts RAM select; release of the interrupt clears it.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_cut_reg <= 1'b0;
    end else if (!pfi_reg) begin
      ram_cut_reg <= 1'b0;
    end else if (!halt_s_n) begin
      ram_cut_reg <= 1'b1;
    end
  end

  // Reset drops a short time after the interrupt and rises only after a long quiet time.
  // The counter is cleared while reset is held under the interrupt, so the release delay counts from recovery.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pfr_cnt_reg        <= '0;
      power_fail_reset_n <= 1'b0;
    end else if (pfi_reg) begin
      if (!power_fail_reset_n) begin
        pfr_cnt_reg <= '0;
      end else if (pfr_cnt_reg >= CW'(cgpf_pkg::PFR_ASSERT_CYC)) begin
        power_fail_reset_n <= 1'b0;
        pfr_cnt_reg        <= '0;
      end else begin
        pfr_cnt_reg <= pfr_cnt_reg + 1'b1;
      end
    end else if (!power_fail_reset_n) begin
      if (pfr_cnt_reg >= CW'(PFR_RELEASE_CYC)) begin
        power_fail_reset_n <= 1'b1;
        pfr_cnt_reg        <= '0;
      end else begin
        pfr_cnt_reg <= pfr_cnt_reg + 1'b1;
      end
    end else begin
      pfr_cnt_reg <= '0;
    end
  end

  // ------------------------------------------------------------------
  // Processor clock
  // ------------------------------------------------------------------
  logic osc_en_reg;

  // Oscillator-rate enable, then a divide-by-two flip-flop.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_en_reg <= 1'b0;
      cpu_clk    <= 1'b0;
      cpu_clk_en <= 1'b0;
    end else begin
      osc_en_reg <= !osc_en_reg;
      cpu_clk_en <= osc_en_reg && !cpu_clk;       // Rising edge of the processor clock.
      if (osc_en_reg) begin
        cpu_clk <= !cpu_clk;
      end
    end
  end

  // ------------------------------------------------------------------
  // Strobes and address decode
  // ------------------------------------------------------------------
  logic       mem_cyc;
  logic       io_cyc;
  logic [3:0] io_grp;
  logic       io_wr_hit_reg;

  assign mem_cyc = !mreq_s_n && (!rd_s_n || !wr_s_n);
  assign io_cyc  = !iorq_s_n && (!rd_s_n || !wr_s_n);
  assign io_grp  = addr_s[cgpf_pkg::IO_GRP_MSB:cgpf_pkg::IO_GRP_LSB];

  // Qualified transfer strobes and memory selects.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rd_n <= 1'b1;
      mem_wr_n <= 1'b1;
      io_rd_n  <= 1'b1;
      io_wr_n  <= 1'b1;
      ram_cs_n <= 1'b1;
      rom_cs_n <= 1'b1;
    end else begin
      mem_rd_n <= !(!mreq_s_n && !rd_s_n);
      mem_wr_n <= !(!mreq_s_n && !wr_s_n);
      io_rd_n  <= !(!iorq_s_n && !rd_s_n);
      io_wr_n  <= !(!iorq_s_n && !wr_s_n);
      ram_cs_n <= !(mem_cyc && !addr_s[cgpf_pkg::MEM_HALF_BIT] && !ram_cut_reg);
      rom_cs_n <= !(mem_cyc && addr_s[cgpf_pkg::MEM_HALF_BIT]);
    end
  end

  // Peripheral enables come from I/O space only.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      analyzer_write_enable <= 1'b0;
      source_write_enable   <= 1'b0;
      instr_buf_oe          <= 1'b0;
      disp_buf_oe           <= 1'b0;
      int_status_oe         <= 1'b0;
    end else begin
      analyzer_write_enable <= io_cyc && !wr_s_n && io_grp == cgpf_pkg::IO_ANALYZER;
      source_write_enable   <= io_cyc && !wr_s_n && io_grp == cgpf_pkg::IO_SOURCE;
      instr_buf_oe          <= io_cyc && (io_grp == cgpf_pkg::IO_ANALYZER ||
                                          io_grp == cgpf_pkg::IO_SOURCE);
      disp_buf_oe           <= io_cyc && (io_grp == cgpf_pkg::IO_DIGIT ||
                                          io_grp == cgpf_pkg::IO_ANNUN);
      int_status_oe         <= io_cyc && !rd_s_n && io_grp == cgpf_pkg::IO_INTSTAT;
    end
  end

  // ------------------------------------------------------------------
  // Interrupt merge
  // ------------------------------------------------------------------
  // Both sources share one request; the status buffer tells them apart.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_int_n  <= 1'b1;
      int_status <= 2'h0;
    end else begin
      cpu_int_n  <= !(bint_s || kint_s);
      int_status <= {kint_s, bint_s};
    end
  end

  // ------------------------------------------------------------------
  // Relay supply hold-off
  // ------------------------------------------------------------------
  logic [CW-1:0] relay_cnt_reg;

  // Relays stay unpowered for the hold-off time after reset.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      relay_cnt_reg   <= '0;
      relay_supply_en <= 1'b0;
    end else if (relay_cnt_reg >= CW'(RELAY_HOLD_CYC)) begin
      relay_supply_en <= 1'b1;
    end else begin
      relay_cnt_reg <= relay_cnt_reg + 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Display controller
  // ------------------------------------------------------------------
  logic [cgpf_pkg::NIB_W-1:0] digit_mem [DIGITS];
  logic                       wr_start;
  logic [CW-1:0]              scan_cnt_reg;
  logic [DIG_W-1:0]           scan_idx_reg;
  logic                       scan_step;

  assign wr_start  = !io_wr_n && !io_wr_hit_reg;
  assign scan_step = scan_cnt_reg >= CW'(SCAN_DIGIT_CYC - 1);

  // Marks the I/O write already taken so each write lands once.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_wr_hit_reg <= 1'b0;
    end else begin
      io_wr_hit_reg <= !io_wr_n;
    end
  end

  // Digit codes written by the processor, one entry per digit.
  for (genvar d = 0; d < DIGITS; d++) begin : g_digit
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        digit_mem[d] <= '0;
      end else if (wr_start && io_grp == cgpf_pkg::IO_DIGIT &&
                   addr_s[cgpf_pkg::IO_IDX_MSB:0] == 4'(d)) begin
        digit_mem[d] <= data_s[cgpf_pkg::NIB_W-1:0];
      end
    end
  end

  // Annunciators hold their latched value and are never scanned.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      annunciator <= '0;
    end else if (wr_start && io_grp == cgpf_pkg::IO_ANNUN) begin
      annunciator <= data_s[ANNUN_W-1:0];
    end
  end

  // Scan timer steps the active digit at the dwell rate.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_cnt_reg <= '0;
      scan_idx_reg <= '0;
    end else if (scan_step) begin
      scan_cnt_reg <= '0;
      scan_idx_reg <= (scan_idx_reg == DIG_W'(DIGITS - 1)) ? '0 : scan_idx_reg + 1'b1;
    end else begin
      scan_cnt_reg <= scan_cnt_reg + 1'b1;
    end
  end

  // One cathode low at a time, segments decoded from the stored code.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cathode_n <= '1;
      seg       <= '0;
    end else begin
      cathode_n <= ~(DIGITS'(1) << scan_idx_reg);
      seg       <= cgpf_pkg::SEG_LUT[digit_mem[scan_idx_reg]];
    end
  end

endmodule : cgpf_glue
`default_nettype wire

// >>> tb/cgpf_glue_properties.sv
// Concurrent checks on the glue outputs, bound into every cgpf_glue instance.
// Assumes one clock domain and the short count parameters of the bench.
`timescale 1ns/10ps
`default_nettype none
module cgpf_glue_chk #(
  parameter int unsigned PFR_RELEASE_CYC = 20,
  parameter int unsigned RELAY_HOLD_CYC  = 50
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic supply_low,
  input wire logic cpu_halt_n,
  input wire logic busctl_int,
  input wire logic key_int,
  input wire logic power_fail_interrupt_n,
  input wire logic power_fail_reset_n,
  input wire logic ram_cs_n,
  input wire logic rom_cs_n,
  input wire logic mem_rd_n,
  input wire logic mem_wr_n,
  input wire logic io_wr_n,
  input wire logic cpu_clk,
  input wire logic cpu_clk_en,
  input wire logic cpu_int_n,
  input wire logic analyzer_write_enable,
  input wire logic instr_buf_oe,
  input wire logic relay_supply_en
);
  localparam int REL_LO = PFR_RELEASE_CYC - 10;
  localparam int REL_HI = PFR_RELEASE_CYC - 4;
  logic [15:0] age_reg;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Cycles since reset release; saturates so a long run cannot wrap it.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) age_reg <= 16'h0000;
    else if (age_reg != 16'hFFFF) age_reg <= age_reg + 16'h0001;
  end

  // Processor clock: two reference cycles high, two low.
  sequence s_clk_period;
    cpu_clk [*2] ##1 !cpu_clk [*2] ##1 cpu_clk;
  endsequence
  // Reset stays low well past recovery and lets go near the release count.
  sequence s_rst_release;
    !power_fail_reset_n [*8] ##[REL_LO:REL_HI] power_fail_reset_n;
  endsequence

  pfi_assert_a: assert property (supply_low [*8] |-> !power_fail_interrupt_n)
    else $error("interrupt missing on supply drop");
  pfi_release_a: assert property (!supply_low [*8] |-> power_fail_interrupt_n)
    else $error("interrupt held after recovery");
  reset_follow_a: assert property ($fell(power_fail_interrupt_n) |-> ##[18:24] !power_fail_reset_n)
    else $error("reset did not follow interrupt");
  reset_hold_a: assert property ($rose(power_fail_interrupt_n) |-> s_rst_release)
    else $error("reset release out of window");
  ram_cut_a: assert property ((!cpu_halt_n && !power_fail_interrupt_n) [*8] |-> ram_cs_n)
    else $error("RAM select not cut after halt");
  clk_div_a: assert property ($rose(cpu_clk) |-> s_clk_period)
    else $error("processor clock not divided by four");
  clk_en_a: assert property (cpu_clk_en == $rose(cpu_clk))
    else $error("clock enable not on processor clock rise");
  int_set_a: assert property ((busctl_int || key_int) [*7] |-> !cpu_int_n)
    else $error("shared request missing");
  ana_gate_a: assert property (analyzer_write_enable |-> !io_wr_n && instr_buf_oe)
    else $error("analyzer enable outside I/O write");
  instr_idle_a: assert property (instr_buf_oe |-> mem_rd_n && mem_wr_n)
    else $error("instrument buffer on in memory cycle");
  mem_split_a: assert property (!(ram_cs_n && rom_cs_n) |-> (ram_cs_n != rom_cs_n) && !(mem_rd_n && mem_wr_n))
    else $error("memory select without strobe or both halves");
  relay_hold_a: assert property (age_reg < RELAY_HOLD_CYC - 2 |-> !relay_supply_en)
    else $error("relay supply on too early");
endmodule : cgpf_glue_chk

bind cgpf_glue cgpf_glue_chk #(.PFR_RELEASE_CYC(PFR_RELEASE_CYC), .RELAY_HOLD_CYC(RELAY_HOLD_CYC))
  u_chk (.ref_clk, .rst_n, .supply_low, .cpu_halt_n, .busctl_int, .key_int,
    .power_fail_interrupt_n, .power_fail_reset_n, .ram_cs_n, .rom_cs_n, .mem_rd_n, .mem_wr_n,
    .io_wr_n, .cpu_clk, .cpu_clk_en, .cpu_int_n, .analyzer_write_enable, .instr_buf_oe,
    .relay_supply_en);
`default_nettype wire

// >>> tb/cgpf_cpu_model.sv
// Processor model: bus cycles on request, halt after a non-maskable interrupt.
// Assumes its tasks are called just after a falling clock edge.
`timescale 1ns/10ps
`default_nettype none
module cgpf_cpu_model (
  input  wire logic        clk,
  input  wire logic        nmi_n,
  input  wire logic        rst_n,
  output logic             halt_n,
  output logic             mreq_n,
  output logic             iorq_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic [15:0]      addr,
  output logic [7:0]       data
);
  // Starts a memory or I/O cycle; the caller holds it several cycles.
  task automatic cyc_start(input logic io, input logic wr, input logic [15:0] a,
                           input logic [7:0] d);
    mreq_n = io;
    iorq_n = !io;
    rd_n = wr;
    wr_n = !wr;
    addr = a;
    data = d;
  endtask : cyc_start

  // Ends a cycle; strobes return high, address and data show the inverse of their last value.
  task automatic cyc_end;
    {mreq_n, iorq_n, rd_n, wr_n} = 4'hF;
    addr = ~addr;
    data = ~data;
  endtask : cyc_end

  initial begin
    halt_n = 1'b1;
    addr = 16'h0000;
    data = 8'h00;
    cyc_end();
  end

  // Halts on the interrupt; a reset brings the processor out of halt.
  always @(negedge clk) halt_n <= !rst_n || nmi_n;
endmodule : cgpf_cpu_model
`default_nettype wire

// >>> tb/cgpf_glue_tb_top.sv
// Self-checking bench for cgpf_glue with a processor model on its bus pins.
// Assumes short count parameters, so the run takes well under a thousand cycles.
`timescale 1ns/10ps
`default_nettype none
module cgpf_glue_tb_top;
  localparam int unsigned REL   = 20;
  localparam int unsigned RELAY = 50;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        supply_low = 1'b0;
  logic        busctl_int = 1'b0;
  logic        key_int = 1'b0;
  logic        cpu_halt_n, cpu_mreq_n, cpu_iorq_n, cpu_rd_n, cpu_wr_n, cpu_clk, cpu_clk_en;
  logic        power_fail_interrupt_n, cpu_nmi_n, power_fail_reset_n, ram_cs_n, rom_cs_n;
  logic        mem_rd_n, mem_wr_n, io_rd_n, io_wr_n, cpu_int_n, int_status_oe, disp_buf_oe;
  logic        analyzer_write_enable, source_write_enable, instr_buf_oe, relay_supply_en;
  logic [15:0] cpu_addr, cathode_n;
  logic [10:0] strb;
  logic [7:0]  cpu_data, annunciator;
  logic [6:0]  seg;
  logic [1:0]  int_status;
  int          err_total = 0;
  int          n_compared = 0;
  int          cyc = 0;

  // Reference clock at 20 MHz.
  always #25 ref_clk = ~ref_clk;

  cgpf_glue #(.PFR_RELEASE_CYC(REL), .RELAY_HOLD_CYC(RELAY), .SCAN_DIGIT_CYC(4)) dut (
    .ref_clk, .rst_n, .supply_low, .cpu_halt_n, .cpu_mreq_n, .cpu_iorq_n, .cpu_rd_n,
    .cpu_wr_n, .cpu_addr, .cpu_data, .busctl_int, .key_int, .power_fail_interrupt_n,
    .cpu_nmi_n, .power_fail_reset_n, .ram_cs_n, .rom_cs_n, .mem_rd_n, .mem_wr_n, .io_rd_n,
    .io_wr_n, .cpu_clk, .cpu_clk_en, .cpu_int_n, .int_status, .int_status_oe,
    .analyzer_write_enable, .source_write_enable, .instr_buf_oe, .disp_buf_oe,
    .relay_supply_en, .seg, .cathode_n, .annunciator);
  cgpf_cpu_model cpu (.clk(ref_clk), .nmi_n(cpu_nmi_n), .rst_n(power_fail_reset_n),
    .halt_n(cpu_halt_n), .mreq_n(cpu_mreq_n), .iorq_n(cpu_iorq_n), .rd_n(cpu_rd_n),
    .wr_n(cpu_wr_n), .addr(cpu_addr), .data(cpu_data));

  // All selects, strobes and buffer enables in one word for table compares.
  assign strb = {ram_cs_n, rom_cs_n, mem_rd_n, mem_wr_n, io_rd_n, io_wr_n,
    analyzer_write_enable, source_write_enable, instr_buf_oe, disp_buf_oe, int_status_oe};

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc_n

  // One processor cycle: outputs checked mid-cycle, and idle after release.
  task automatic t_cycle(input logic io, input logic wr, input logic [15:0] a,
                         input logic [7:0] d, input logic [10:0] exp);
    cpu.cyc_start(io, wr, a, d);
    cyc_n(8);
    chk(strb, exp);
    cpu.cyc_end();
    cyc_n(8);
    chk(strb, 11'h7E0);
  endtask : t_cycle

  // Bounded wait for the power-fail reset to reach a level; n counts cycles.
  task automatic wait_pfr(input logic v, output int n);
    n = 0;
    while (power_fail_reset_n !== v && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
  endtask : wait_pfr

  task automatic t_reset;
    int n;
    chk({power_fail_reset_n, relay_supply_en}, 2'b00);
    wait_pfr(1'b1, n);
    chk(n >= REL - 2 && n <= REL + 3, 1'b1);
    while (relay_supply_en !== 1'b1 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    chk(n >= RELAY - 2 && n <= RELAY + 3, 1'b1);
  endtask : t_reset

  task automatic t_decode;
    t_cycle(1'b0, 1'b0, 16'h7FFF, 8'h00, 11'h2E0);
    t_cycle(1'b0, 1'b1, 16'h8000, 8'h3C, 11'h560);
    t_cycle(1'b0, 1'b1, 16'h0010, 8'h22, 11'h360);
    t_cycle(1'b1, 1'b1, 16'h0000, 8'h11, 11'h7D4);
    t_cycle(1'b1, 1'b1, 16'h0010, 8'h22, 11'h7CC);
    t_cycle(1'b1, 1'b0, 16'h0000, 8'h00, 11'h7A4);
    t_cycle(1'b1, 1'b1, 16'h0023, 8'h05, 11'h7C2);
    t_cycle(1'b1, 1'b1, 16'h0030, 8'hA5, 11'h7C2);
    t_cycle(1'b1, 1'b1, 16'h0040, 8'h00, 11'h7C0);
    t_cycle(1'b1, 1'b0, 16'h0050, 8'h00, 11'h7A1);
  endtask : t_decode

  task automatic t_display;
    int n = 0;
    while (cathode_n[3] !== 1'b0 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    chk({cathode_n, seg}, {16'hFFF7, 7'h6D});
    cyc_n(70);
    chk(annunciator, 8'hA5);
  endtask : t_display

  task automatic t_irq;
    for (int i = 1; i < 4; i++) begin
      {key_int, busctl_int} = i[1:0];
      cyc_n(8);
      chk(cpu_int_n, 1'b0);
      cpu.cyc_start(1'b1, 1'b0, 16'h0050, 8'h00);
      cyc_n(8);
      chk({int_status_oe, int_status}, {1'b1, i[1:0]});
      cpu.cyc_end();
      {key_int, busctl_int} = 2'b00;
      cyc_n(8);
      chk(cpu_int_n, 1'b1);
    end
  endtask : t_irq

  task automatic t_power_fail;
    int n;
    supply_low = 1'b1;
    cyc_n(8);
    chk({power_fail_interrupt_n, cpu_nmi_n}, 2'b00);
    wait_pfr(1'b0, n);
    chk(n >= 14 && n <= 22, 1'b1);
    t_cycle(1'b0, 1'b0, 16'h1000, 8'h00, 11'h6E0);
    supply_low = 1'b0;
    cyc_n(8);
    chk({power_fail_interrupt_n, cpu_nmi_n}, 2'b11);
    wait_pfr(1'b1, n);
    chk(n >= 14 && n <= 22, 1'b1);
    t_cycle(1'b0, 1'b0, 16'h1000, 8'h00, 11'h2E0);
  endtask : t_power_fail

  task automatic test_done;
    $display("compares %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // Cuts a hang short after far more cycles than the tests need.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      test_done();
    end
  end

  initial begin
    cyc_n(16);
    rst_n = 1'b1;
    t_reset();
    t_decode();
    t_display();
    t_irq();
    t_power_fail();
    test_done();
  end
endmodule : cgpf_glue_tb_top
`default_nettype wire
